/* rtl/arf_pkg.sv */
// Constants for the analyzer register bank: map, fields, codes, limits.
// Assumes a 100 MHz clock and an APB master with 8-bit byte addresses.
package arf_pkg;
   localparam logic [7:0] ADDR_DISPLAY   = 8'h00;
   localparam logic [7:0] ADDR_UNITS     = 8'h04;
   localparam logic [7:0] ADDR_STATUS    = 8'h08;
   localparam logic [7:0] ADDR_ALARM_CFG = 8'h0C;
   localparam logic [7:0] ADDR_ALARM1_SP = 8'h10;
   localparam logic [7:0] ADDR_ALARM2_SP = 8'h14;
   localparam logic [7:0] ADDR_CLK_HOUR  = 8'h18;
   localparam logic [7:0] ADDR_CLK_MIN   = 8'h1C;
   localparam logic [7:0] ADDR_CLK_READ  = 8'h20;

   localparam logic [15:0] RST_DISPLAY   = 16'h6432;
   localparam logic [15:0] RST_UNITS     = 16'h0000;
   localparam logic [15:0] RST_ALARM_CFG = 16'h0000;
   localparam logic [15:0] UNITS_MASK    = 16'h383F;
   localparam logic [15:0] ALARM_MASK    = 16'h001F;

   localparam logic [7:0] PCT_MAX  = 8'h64;
   localparam logic [7:0] PCT_STEP = 8'h0A;

   typedef enum logic [1:0] {
      ARF_ROLE_OFF  = 2'b00,
      ARF_ROLE_LOW  = 2'b01,
      ARF_ROLE_HIGH = 2'b10
   } arf_role_t;

   // Raw code offsets of the fixed-point formats
   localparam logic [15:0] TYPEF_ZERO = 16'h4E20;
   localparam logic [15:0] TYPEF_MAX  = 16'h9C40;
   localparam logic [15:0] TYPEG_ZERO = 16'h4E20;
   localparam logic [15:0] TYPEG_MAX  = 16'h9C40;
   localparam logic [15:0] TYPEK_ZERO = 16'h7FFF;
   localparam logic [16:0] TYPEF_SCALE = 17'h0000A;

   // External sensor spans as one-decimal codes: dew point, temperature, pressure
   localparam logic [15:0] EXT_DP_MIN_C = 16'h4A38;
   localparam logic [15:0] EXT_DP_MAX_C = 16'h4EE8;
   localparam logic [15:0] EXT_DP_MIN_F = 16'h4858;
   localparam logic [15:0] EXT_DP_MAX_F = 16'h50C8;
   localparam logic [15:0] EXT_DP_MIN_K = 16'h54E2;
   localparam logic [15:0] EXT_DP_MAX_K = 16'h5992;
   localparam logic [15:0] EXT_T_MIN_C  = 16'h4C2C;
   localparam logic [15:0] EXT_T_MAX_C  = 16'h5208;
   localparam logic [15:0] EXT_T_MIN_F  = 16'h4BDC;
   localparam logic [15:0] EXT_T_MAX_F  = 16'h5668;
   localparam logic [15:0] EXT_T_MIN_K  = 16'h56D6;
   localparam logic [15:0] EXT_T_MAX_K  = 16'h5CB2;
   localparam logic [15:0] EXT_P_MAX_PSI = 16'h4FD9;
   localparam logic [15:0] EXT_P_MAX_BAR = 16'h4E3E;
   localparam logic [15:0] EXT_P_MAX_KPA = 16'h5A00;

   // Fault window limits
   localparam logic [15:0] LOOP_MIN_UA   = 16'h0E10;
   localparam logic [15:0] LOOP_MAX_UA   = 16'h5208;
   localparam logic [15:0] CELL_MIN_CODE = 16'h4C2C;
   localparam logic [15:0] CELL_MAX_CODE = 16'h5140;
   localparam logic [15:0] PRESS_MIN     = 16'h02BC;
   localparam logic [15:0] PRESS_MAX     = 16'h0514;
   localparam logic [15:0] VCOMP_MIN     = 16'h0001;
   localparam logic [15:0] VCOMP_MAX     = 16'h1FFF;
   localparam logic [16:0] CELL_BAND     = 17'h00001;

   localparam logic [7:0]  LOOP_ERR_LO_X10 = 8'h20;
   localparam logic [7:0]  LOOP_ERR_HI_X10 = 8'hD6;

   localparam logic [63:0] CLK_HZ      = 64'h0000_0000_05F5_E100;
   localparam logic [63:0] STABLE_MIN  = 64'h0000_0000_0000_000F;
   localparam logic [63:0] SEC_PER_MIN = 64'h0000_0000_0000_003C;
   localparam logic [63:0] STABLE_CYC  = STABLE_MIN * SEC_PER_MIN * CLK_HZ;
   localparam logic [63:0] FLASH_MS    = 64'h0000_0000_0000_01F4;
   localparam logic [63:0] MS_PER_S    = 64'h0000_0000_0000_03E8;
   localparam logic [63:0] FLASH_CYC   = FLASH_MS * CLK_HZ / MS_PER_S;
endpackage

/* rtl/arf_regs.sv */
// Analyzer register bank: display, units, alarm setup, clock set, status word.
// Assumes an APB master on i_clk and measurement codes synchronous to i_clk.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Display brightness and contrast fields hold 0..100 in steps of ten.
// - Units bits 1:0 temperature unit, bits 3:2 pressure unit, codes 00/01/10.
// - Units bit 4 selects one-gas offset or two-gas field calibration.
// - Units bit 5 selects non-US or US date ordering.
// - Units bits 13:11 code external sensor quantity: none, dew, temp, press, other.
// - One-decimal values are raw 0..40000, value is (raw-20000)/10.
// - Two-decimal values are raw 0..40000, value is (raw-20000)/100.
// - External sensor span is fixed per quantity and selected unit.
// - Integer signed values use raw 0..65535, value is raw minus 32767.
// - Read-only status; bit 2 low alarm, yellow one; bit 3 high alarm, yellow two.
// - Status bit 1 set while oxygen reading is outside calibrated range.
// - Status bit 4 when compensation current below 3.6 or above 21 mA; red flash.
// - Status bit 5 when sensor current leaves 3.6..21 mA; red flash.
// - Status bit 6 until cell temperature within band of setpoint for 15 minutes.
// - Status bit 7 when cell temperature below -50 or above 80 C; red solid.
// - Status bit 8 when pressure below 700 or above 1300 mbar; red solid.
// - Status bit 9 when compensated voltage code <=1 or >=8191; red solid.
// - Status bit 10 when board temperature exceeds cell setpoint; red solid.
// - Clock reads pack one value per byte; writes use only the low byte.
// - Alarm config bits 1:0 set alarm one role: off, low, high.
// - Alarm config bits 3:2 set alarm two role with the same coding.
// - Alarm config bit 4 selects fault loop level 3.2 mA or 21.4 mA.
module arf_regs
   import arf_pkg::*;
#(
   parameter logic [63:0] STABLE_CYCLES = STABLE_CYC,
   parameter logic [63:0] FLASH_CYCLES  = FLASH_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic      [31:0] o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   input  wire logic        i_fast_response_filter,
   input  wire logic [15:0] i_o2_code,
   input  wire logic [15:0] i_o2_cal_lo,
   input  wire logic [15:0] i_o2_cal_hi,
   input  wire logic [15:0] i_comp_ua,
   input  wire logic [15:0] i_ext_ua,
   input  wire logic [15:0] i_cell_temp_code,
   input  wire logic [15:0] i_cell_setpoint_c,
   input  wire logic [15:0] i_press_mbar,
   input  wire logic [15:0] i_vcomp_code,
   input  wire logic [15:0] i_pcb_temp_code,
   input  wire logic [7:0]  i_clk_sec,
   input  wire logic [7:0]  i_clk_day,
   output logic      [7:0]  o_brightness,
   output logic      [7:0]  o_contrast,
   output logic      [1:0]  o_temp_unit,
   output logic      [1:0]  o_press_unit,
   output logic             o_cal_two_gas,
   output logic             o_date_us,
   output logic      [2:0]  o_ext_quantity,
   output logic      [15:0] o_ext_span_min,
   output logic      [15:0] o_ext_span_max,
   output logic      [1:0]  o_alarm1_role,
   output logic      [1:0]  o_alarm2_role,
   output logic             o_loop_err_high,
   output logic      [7:0]  o_loop_err_ma_x10,
   output logic      [7:0]  o_clk_hour,
   output logic      [7:0]  o_clk_min,
   output logic             o_clk_load,
   output logic             o_led_yellow1,
   output logic             o_led_yellow2,
   output logic             o_led_red
);
   logic [15:0] display;
   logic [15:0] units;
   logic [15:0] alarm_cfg;
   logic [15:0] alarm1_sp;
   logic [15:0] alarm2_sp;
   logic [15:0] status;
   logic [15:0] next_status;
   logic [36:0] stable_cnt;
   logic [31:0] flash_cnt;
   logic        flash_phase;
   logic        setup;
   logic        wr;
   logic        mapped;
   logic        in_band;
   logic [16:0] sp_code;
   logic        al1_act;
   logic        al2_act;
   logic        rst_done;

   function automatic logic pct_ok(input logic [7:0] v);
      return (v <= PCT_MAX) && ((v % PCT_STEP) == 8'h00);
   endfunction

   assign setup = i_psel && !i_penable;
   assign wr    = i_psel && i_penable && i_pwrite;
   assign o_pready = 1'b1;

   always_comb begin
      case (i_paddr)
         ADDR_DISPLAY, ADDR_UNITS, ADDR_STATUS, ADDR_ALARM_CFG, ADDR_ALARM1_SP,
         ADDR_ALARM2_SP, ADDR_CLK_HOUR, ADDR_CLK_MIN, ADDR_CLK_READ: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Read data and error are latched in the setup phase so they come from flops
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else if (setup) begin
         o_pslverr <= !mapped || (i_pwrite && (i_paddr == ADDR_STATUS ||
                      i_paddr == ADDR_CLK_READ));
         case (i_paddr)
            ADDR_DISPLAY:   o_prdata <= {16'h0000, display};
            ADDR_UNITS:     o_prdata <= {16'h0000, units};
            ADDR_STATUS:    o_prdata <= {16'h0000, status};
            ADDR_ALARM_CFG: o_prdata <= {16'h0000, alarm_cfg};
            ADDR_ALARM1_SP: o_prdata <= {16'h0000, alarm1_sp};
            ADDR_ALARM2_SP: o_prdata <= {16'h0000, alarm2_sp};
            ADDR_CLK_HOUR:  o_prdata <= {24'h00_0000, o_clk_hour};
            ADDR_CLK_MIN:   o_prdata <= {24'h00_0000, o_clk_min};
            ADDR_CLK_READ:  o_prdata <= {o_clk_hour, o_clk_min, i_clk_sec, i_clk_day};
            default:        o_prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Each display field is checked on its own; a bad value leaves that field alone
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         display <= RST_DISPLAY;
      end else if (wr && i_paddr == ADDR_DISPLAY) begin
         if (pct_ok(i_pwdata[15:8])) begin
            display[15:8] <= i_pwdata[15:8];
         end
         if (pct_ok(i_pwdata[7:0])) begin
            display[7:0] <= i_pwdata[7:0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         units <= RST_UNITS;
      end else if (wr && i_paddr == ADDR_UNITS) begin
         units <= i_pwdata[15:0] & UNITS_MASK;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         alarm_cfg <= RST_ALARM_CFG;
      end else if (wr && i_paddr == ADDR_ALARM_CFG) begin
         alarm_cfg <= i_pwdata[15:0] & ALARM_MASK;
      end
   end

   // Set points beyond the two-decimal code range are refused
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         alarm1_sp <= TYPEG_ZERO;
         alarm2_sp <= TYPEG_ZERO;
      end else if (wr && i_pwdata[15:0] <= TYPEG_MAX) begin
         if (i_paddr == ADDR_ALARM1_SP) begin
            alarm1_sp <= i_pwdata[15:0];
         end
         if (i_paddr == ADDR_ALARM2_SP) begin
            alarm2_sp <= i_pwdata[15:0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_clk_hour <= 8'h00;
         o_clk_min  <= 8'h00;
         o_clk_load <= 1'b0;
      end else begin
         o_clk_load <= wr && (i_paddr == ADDR_CLK_HOUR || i_paddr == ADDR_CLK_MIN);
         if (wr && i_paddr == ADDR_CLK_HOUR) begin
            o_clk_hour <= i_pwdata[7:0];
         end
         if (wr && i_paddr == ADDR_CLK_MIN) begin
            o_clk_min <= i_pwdata[7:0];
         end
      end
   end

   assign o_brightness   = display[15:8];
   assign o_contrast     = display[7:0];
   assign o_temp_unit    = units[1:0];
   assign o_press_unit   = units[3:2];
   assign o_cal_two_gas  = units[4];
   assign o_date_us      = units[5];
   assign o_ext_quantity = units[13:11];
   assign o_alarm1_role  = alarm_cfg[1:0];
   assign o_alarm2_role  = alarm_cfg[3:2];
   assign o_loop_err_high = alarm_cfg[4];
   assign o_loop_err_ma_x10 = alarm_cfg[4] ? LOOP_ERR_HI_X10 : LOOP_ERR_LO_X10;

   // Span in one-decimal codes for the chosen quantity and unit
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_ext_span_min <= TYPEF_ZERO;
         o_ext_span_max <= TYPEF_ZERO;
      end else begin
         case (units[13:11])
            3'b001: begin
               o_ext_span_min <= (units[1:0] == 2'b01) ? EXT_DP_MIN_F :
                                 (units[1:0] == 2'b10) ? EXT_DP_MIN_K : EXT_DP_MIN_C;
               o_ext_span_max <= (units[1:0] == 2'b01) ? EXT_DP_MAX_F :
                                 (units[1:0] == 2'b10) ? EXT_DP_MAX_K : EXT_DP_MAX_C;
            end
            3'b010: begin
               o_ext_span_min <= (units[1:0] == 2'b01) ? EXT_T_MIN_F :
                                 (units[1:0] == 2'b10) ? EXT_T_MIN_K : EXT_T_MIN_C;
               o_ext_span_max <= (units[1:0] == 2'b01) ? EXT_T_MAX_F :
                                 (units[1:0] == 2'b10) ? EXT_T_MAX_K : EXT_T_MAX_C;
            end
            3'b011: begin
               o_ext_span_min <= TYPEF_ZERO;
               o_ext_span_max <= (units[3:2] == 2'b01) ? EXT_P_MAX_BAR :
                                 (units[3:2] == 2'b10) ? EXT_P_MAX_KPA : EXT_P_MAX_PSI;
            end
            default: begin
               o_ext_span_min <= TYPEF_ZERO;
               o_ext_span_max <= TYPEF_MAX;
            end
         endcase
      end
   end

   // Setpoint in one-decimal code; the band is one code step since 0.15 C is not a code
   assign sp_code = 17'(TYPEF_ZERO) + 17'(i_cell_setpoint_c) * TYPEF_SCALE;
   assign in_band = ({1'b0, i_cell_temp_code} + CELL_BAND >= sp_code) &&
                    ({1'b0, i_cell_temp_code} <= sp_code + CELL_BAND);

   always_ff @(posedge i_clk) begin
      if (!i_rst_n || !in_band) begin
         stable_cnt <= 37'h0_0000_0000;
      end else if (64'(stable_cnt) < STABLE_CYCLES) begin
         stable_cnt <= stable_cnt + 37'h0_0000_0001;
      end
   end

   // Alarm comparisons work on raw codes, which keep the order of real values
   assign al1_act = (alarm_cfg[1:0] == ARF_ROLE_LOW  && i_o2_code < alarm1_sp) ||
                    (alarm_cfg[1:0] == ARF_ROLE_HIGH && i_o2_code > alarm1_sp);
   assign al2_act = (alarm_cfg[3:2] == ARF_ROLE_LOW  && i_o2_code < alarm2_sp) ||
                    (alarm_cfg[3:2] == ARF_ROLE_HIGH && i_o2_code > alarm2_sp);

   always_comb begin
      next_status     = 16'h0000;
      next_status[0]  = i_fast_response_filter;
      next_status[1]  = i_o2_code < i_o2_cal_lo || i_o2_code > i_o2_cal_hi;
      next_status[2]  = (al1_act && alarm_cfg[1:0] == ARF_ROLE_LOW) ||
                        (al2_act && alarm_cfg[3:2] == ARF_ROLE_LOW);
      next_status[3]  = (al1_act && alarm_cfg[1:0] == ARF_ROLE_HIGH) ||
                        (al2_act && alarm_cfg[3:2] == ARF_ROLE_HIGH);
      next_status[4]  = i_comp_ua < LOOP_MIN_UA || i_comp_ua > LOOP_MAX_UA;
      next_status[5]  = i_ext_ua < LOOP_MIN_UA || i_ext_ua > LOOP_MAX_UA;
      next_status[6]  = !in_band || 64'(stable_cnt) < STABLE_CYCLES;
      next_status[7]  = i_cell_temp_code < CELL_MIN_CODE ||
                        i_cell_temp_code > CELL_MAX_CODE;
      next_status[8]  = i_press_mbar < PRESS_MIN || i_press_mbar > PRESS_MAX;
      next_status[9]  = i_vcomp_code <= VCOMP_MIN || i_vcomp_code >= VCOMP_MAX;
      next_status[10] = {1'b0, i_pcb_temp_code} >
                        17'(TYPEK_ZERO) + 17'(i_cell_setpoint_c);
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         status <= 16'h0000;
      end else begin
         status <= next_status;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         flash_cnt   <= 32'h0000_0000;
         flash_phase <= 1'b0;
      end else if (64'(flash_cnt) >= FLASH_CYCLES - 64'h1) begin
         flash_cnt   <= 32'h0000_0000;
         flash_phase <= !flash_phase;
      end else begin
         flash_cnt <= flash_cnt + 32'h0000_0001;
      end
   end

   assign o_led_yellow1 = status[2];
   assign o_led_yellow2 = status[3];
   // Solid faults override flashing ones, so the red lamp never blinks over a hard fault
   assign o_led_red = (|status[10:6]) || ((|status[5:4]) && flash_phase);

   // Checks wait one edge after reset for live status
   always_ff @(posedge i_clk) begin
      rst_done <= i_rst_n;
   end

   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n || !rst_done);

   AST_DISP_BAD: assert property (
      wr && i_paddr == ADDR_DISPLAY && i_pwdata[15:8] > PCT_MAX
      |=> o_brightness == $past(o_brightness))
      else $error("brightness took an out of range value");

   AST_UNIT_WR: assert property (
      wr && i_paddr == ADDR_UNITS |=> o_temp_unit == $past(i_pwdata[1:0]) &&
      o_ext_quantity == $past(i_pwdata[13:11]))
      else $error("units write not applied");

   AST_SP_RANGE: assert property (
      wr && i_paddr == ADDR_ALARM1_SP && i_pwdata[15:0] > TYPEG_MAX
      |=> $stable(alarm1_sp))
      else $error("setpoint took a code above range");

   AST_LOW_ALARM: assert property (
      alarm_cfg[1:0] == ARF_ROLE_LOW && i_o2_code < alarm1_sp |=> o_led_yellow1)
      else $error("low alarm not shown");

   AST_O2_RANGE: assert property (
      i_o2_code > i_o2_cal_hi |=> status[1])
      else $error("oxygen over range not flagged");

   AST_COMP_LOW: assert property (
      i_comp_ua < LOOP_MIN_UA |=> status[4])
      else $error("compensation current error missing");

   AST_UNSTABLE: assert property (
      !in_band |=> status[6] [*2])
      else $error("cell stable flag cleared too early");

   AST_CELL_HOT: assert property (
      i_cell_temp_code > CELL_MAX_CODE |=> status[7] && o_led_red)
      else $error("cell sensor error missing");

   AST_PRESS: assert property (
      i_press_mbar < PRESS_MIN |=> status[8])
      else $error("pressure error missing");

   AST_VCOMP: assert property (
      i_vcomp_code >= VCOMP_MAX |=> status[9])
      else $error("oxygen sensor error missing");

   AST_CLK_BYTE: assert property (
      wr && i_paddr == ADDR_CLK_HOUR |=> o_clk_hour == $past(i_pwdata[7:0]) && o_clk_load)
      else $error("clock write did not take low byte");

   AST_RED_PRIO: assert property (
      |status[10:6] |-> o_led_red)
      else $error("solid red overridden");

   AST_ALARM_OFF: assert property (
      alarm_cfg[3:0] == 4'h0 |=> !status[2] && !status[3])
      else $error("alarm active while both roles are off");

   COV_STABLE: cover property ($fell(status[6]));
   COV_FLASH: cover property (status[4] && !(|status[10:6]) && $rose(o_led_red));
   COV_HIGH_ALARM: cover property ($rose(o_led_yellow2));
   COV_READ_STATUS: cover property (setup && !i_pwrite && i_paddr == ADDR_STATUS);
endmodule
`default_nettype wire

/* verification/arf_host.sv */
// Host model: APB master that polls and writes the analyzer registers.
// Assumes one caller at a time and a 100 MHz clock shared with the bank.
`timescale 1ns/10ps
`default_nettype none
module arf_host (
   input  wire logic        i_clk,
   input  wire logic [31:0] i_prdata,
   input  wire logic        i_pready,
   input  wire logic        i_pslverr,
   output logic             o_psel,
   output logic             o_penable,
   output logic             o_pwrite,
   output logic      [7:0]  o_paddr,
   output logic      [31:0] o_pwdata
);
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0000_0000;
   end

   // Raw codes of the fixed-point formats, as the host encodes them
   function automatic logic [15:0] code_f(input int tenths);
      return 16'h4E20 + 16'(tenths);
   endfunction
   function automatic logic [15:0] code_g(input int hundredths);
      return 16'h4E20 + 16'(hundredths);
   endfunction
   function automatic logic [15:0] code_k(input int v);
      return 16'h7FFF + 16'(v);
   endfunction

   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      do @(posedge i_clk); while (i_pready !== 1'b1);
      rd = i_prdata;
      err = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // Released data must not keep showing the written word
      o_pwdata <= ~d;
   endtask
endmodule
`default_nettype wire

/* verification/analyzer_register_formats_bench.sv */
// Self-checking bench for the analyzer register bank.
// Assumes the host model drives APB; measurement inputs are set here.
`timescale 1ns/10ps
`default_nettype none
module analyzer_register_formats_bench
   import arf_pkg::*;
;
   localparam logic RD = 1'b0;
   localparam logic WR = 1'b1;
   logic        i_clk = 1'b0, i_rst_n = 1'b0, i_fast_response_filter = 1'b0;
   logic        i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic [7:0]  i_paddr;
   logic [31:0] i_pwdata, o_prdata;
   logic [15:0] i_o2_code = '0, i_comp_ua = '0, i_ext_ua = '0, i_cell_temp_code = '0;
   logic [15:0] i_press_mbar = '0, i_vcomp_code = '0, i_pcb_temp_code = '0;
   logic [15:0] i_o2_cal_lo = 16'h4E20, i_o2_cal_hi = 16'h5DC0, i_cell_setpoint_c = 16'h003C;
   logic [7:0]  i_clk_sec, i_clk_day;
   logic [7:0]  o_brightness, o_contrast, o_clk_hour, o_clk_min, o_loop_err_ma_x10;
   logic [15:0] o_ext_span_min, o_ext_span_max;
   logic [2:0]  o_ext_quantity;
   logic [1:0]  o_temp_unit, o_press_unit, o_alarm1_role, o_alarm2_role;
   logic        o_cal_two_gas, o_date_us, o_loop_err_high, o_clk_load;
   logic        o_led_yellow1, o_led_yellow2, o_led_red;
   int          miscompares = 0, comparisons = 0;

   arf_regs #(
      .STABLE_CYCLES(64'h0000_0000_0000_0014),
      .FLASH_CYCLES (64'h0000_0000_0000_0004)
   ) arf_regs_inst (
      .i_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
      .o_pready, .o_pslverr, .i_fast_response_filter, .i_o2_code, .i_o2_cal_lo,
      .i_o2_cal_hi, .i_comp_ua, .i_ext_ua, .i_cell_temp_code, .i_cell_setpoint_c,
      .i_press_mbar, .i_vcomp_code, .i_pcb_temp_code, .i_clk_sec, .i_clk_day,
      .o_brightness, .o_contrast, .o_temp_unit, .o_press_unit, .o_cal_two_gas, .o_date_us,
      .o_ext_quantity, .o_ext_span_min, .o_ext_span_max, .o_alarm1_role, .o_alarm2_role,
      .o_loop_err_high, .o_loop_err_ma_x10, .o_clk_hour, .o_clk_min, .o_clk_load,
      .o_led_yellow1, .o_led_yellow2, .o_led_red
   );
   arf_host arf_host_inst (
      .i_clk, .i_prdata(o_prdata), .i_pready(o_pready), .i_pslverr(o_pslverr),
      .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
      .o_pwdata(i_pwdata)
   );

   initial begin
      forever #5 i_clk = ~i_clk;
   end

   task automatic conclude;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic e);
      logic [31:0] r;
      logic        s;
      arf_host_inst.xfer(w, a, d, r, s);
      @(negedge i_clk);
      if (w == RD) chk(r, x);
      chk(32'(s), 32'(e));
   endtask

   // Counts high samples of a level over n cycles, taken mid-cycle
   task automatic highs(ref logic s, input int n, output int c);
      c = 0;
      repeat (n) begin
         c += int'(s === 1'b1);
         @(negedge i_clk);
      end
   endtask

   task automatic nominal;
      @(posedge i_clk);
      i_fast_response_filter <= 1'b1;
      i_o2_code <= arf_host_inst.code_g(1000);
      i_comp_ua <= 16'h2EE0;
      i_ext_ua <= 16'h2EE0;
      i_cell_temp_code <= arf_host_inst.code_f(600);
      i_press_mbar <= 16'h03F2;
      i_vcomp_code <= 16'h0800;
      i_pcb_temp_code <= arf_host_inst.code_k(30);
      {i_o2_cal_lo, i_o2_cal_hi, i_clk_sec, i_clk_day} <= 48'h4E20_5DC0_3B1F;
   endtask

   task automatic t_reset;
      acc(RD, ADDR_DISPLAY, 32'h0, {16'h0000, RST_DISPLAY}, 1'b0);
      acc(RD, ADDR_UNITS, 32'h0, 32'h0, 1'b0);
      acc(RD, ADDR_ALARM_CFG, 32'h0, 32'h0, 1'b0);
      acc(RD, ADDR_STATUS, 32'h0, 32'h0000_03F2, 1'b0);
      acc(RD, 8'h24, 32'h0, 32'h0, 1'b1);
      acc(WR, 8'h24, 32'h1, 32'h0, 1'b1);
   endtask

   task automatic t_display;
      acc(WR, ADDR_DISPLAY, 32'h0000_5A0A, 32'h0, 1'b0);
      chk(32'({o_brightness, o_contrast}), 32'h0000_5A0A);
      acc(WR, ADDR_DISPLAY, 32'h0000_6E14, 32'h0, 1'b0);
      acc(RD, ADDR_DISPLAY, 32'h0, 32'h0000_5A14, 1'b0);
      acc(WR, ADDR_DISPLAY, 32'h0000_0005, 32'h0, 1'b0);
      acc(RD, ADDR_DISPLAY, 32'h0, 32'h0000_0014, 1'b0);
   endtask

   task automatic t_units;
      logic [15:0] w;
      logic [15:0] mn;
      logic [15:0] mx;
      for (int i = 0; i < 5; i++) begin
         w = {2'b00, 3'(i), 5'b0_0000, i[0], ~i[0], 2'(i % 3), 2'(i % 3)};
         acc(WR, ADDR_UNITS, {16'hFFFF, w | 16'hC7C0}, 32'h0, 1'b0);
         acc(RD, ADDR_UNITS, 32'h0, {16'h0000, w}, 1'b0);
         chk(32'({o_ext_quantity, o_date_us, o_cal_two_gas, o_press_unit, o_temp_unit}),
             32'({w[13:11], w[5:0]}));
         mn = arf_host_inst.code_f(i == 1 ? -1480 : i == 2 ? 2230 : 0);
         mx = arf_host_inst.code_f(i == 1 ? 680 : i == 2 ? 3730 : 441);
         if (i inside {[1:3]}) chk({o_ext_span_min, o_ext_span_max}, {mn, mx});
      end
   endtask

   task automatic t_alarm;
      logic [15:0] w;
      for (int i = 0; i < 3; i++) begin
         w = {11'h000, i[0], 2'(2 - i), 2'(i)};
         acc(WR, ADDR_ALARM_CFG, {16'h0000, w | 16'hFFE0}, 32'h0, 1'b0);
         acc(RD, ADDR_ALARM_CFG, 32'h0, {16'h0000, w}, 1'b0);
         chk(32'({o_loop_err_high, o_alarm2_role, o_alarm1_role}), 32'(w[4:0]));
         chk(32'(o_loop_err_ma_x10), i[0] ? 32'h0000_00D6 : 32'h0000_0020);
      end
      acc(WR, ADDR_ALARM1_SP, {16'h0000, arf_host_inst.code_g(4000)}, 32'h0, 1'b0);
      acc(WR, ADDR_ALARM2_SP, {16'h0000, arf_host_inst.code_g(0)}, 32'h0, 1'b0);
      acc(WR, ADDR_ALARM1_SP, 32'h0000_9C41, 32'h0, 1'b0);
      acc(WR, ADDR_ALARM_CFG, 32'h0000_0009, 32'h0, 1'b0);
      acc(RD, ADDR_STATUS, 32'h0, 32'h0000_000D, 1'b0);
      chk(32'({o_led_yellow1, o_led_yellow2}), 32'h0000_0003);
      acc(WR, ADDR_ALARM_CFG, 32'h0, 32'h0, 1'b0);
      acc(WR, ADDR_STATUS, 32'h0000_FFFF, 32'h0, 1'b1);
      acc(RD, ADDR_STATUS, 32'h0, 32'h0000_0001, 1'b0);
   endtask

   task automatic t_faults;
      logic [15:0] e[7];
      int          n;
      e = '{16'h0002, 16'h0010, 16'h0020, 16'h00C0, 16'h0100, 16'h0200, 16'h0400};
      for (int k = 0; k < 7; k++) begin
         @(posedge i_clk);
         case (k)
            0: {i_o2_cal_lo, i_o2_cal_hi} <= 32'h3A98_5207;
            1: i_comp_ua <= 16'h0E0F;
            2: i_ext_ua <= 16'h5209;
            3: i_cell_temp_code <= arf_host_inst.code_f(-501);
            4: i_press_mbar <= 16'h02BB;
            5: i_vcomp_code <= 16'h0001;
            default: i_pcb_temp_code <= arf_host_inst.code_k(61);
         endcase
         acc(RD, ADDR_STATUS, 32'h0, {16'h0000, e[k] | 16'h0001}, 1'b0);
         highs(o_led_red, 10, n);
         chk(32'({n == 0, n == 10}), k == 0 ? 32'h2 : k < 3 ? 32'h0 : 32'h1);
         nominal;
         repeat (30) @(posedge i_clk);
      end
      @(posedge i_clk);
      i_comp_ua <= 16'h0E0F;
      i_press_mbar <= 16'h02BB;
      acc(RD, ADDR_STATUS, 32'h0, 32'h0000_0111, 1'b0);
      highs(o_led_red, 10, n);
      chk(32'(n), 32'h0000_000A);
      nominal;
   endtask

   task automatic t_stable;
      @(posedge i_clk);
      i_cell_setpoint_c <= 16'h003D;
      repeat (30) @(posedge i_clk);
      acc(RD, ADDR_STATUS, 32'h0, 32'h0000_0041, 1'b0);
      @(posedge i_clk);
      i_cell_temp_code <= arf_host_inst.code_f(609);
      acc(RD, ADDR_STATUS, 32'h0, 32'h0000_0041, 1'b0);
      repeat (30) @(posedge i_clk);
      acc(RD, ADDR_STATUS, 32'h0, 32'h0000_0001, 1'b0);
   endtask

   task automatic t_clock;
      int n;
      acc(WR, ADDR_CLK_HOUR, 32'h0000_AB17, 32'h0, 1'b0);
      highs(o_clk_load, 3, n);
      chk(32'(n), 32'h0000_0001);
      chk(32'(o_clk_hour), 32'h0000_0017);
      acc(WR, ADDR_CLK_MIN, 32'hFFFF_FF2A, 32'h0, 1'b0);
      chk(32'(o_clk_min), 32'h0000_002A);
      acc(RD, ADDR_CLK_READ, 32'h0, 32'h172A_3B1F, 1'b0);
      acc(WR, ADDR_CLK_READ, 32'h0000_0001, 32'h0, 1'b1);
   endtask

   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      t_reset;
      nominal;
      t_display;
      t_units;
      t_alarm;
      t_faults;
      t_stable;
      t_clock;
      conclude;
   end

   // Whole run needs about 550 cycles
   initial begin
      repeat (5000) @(posedge i_clk);
      miscompares++;
      conclude;
   end
endmodule
`default_nettype wire
